// ### rtl/pbfl_pkg.sv
package pbfl_pkg;
   // ==========================================
   // Widths
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int NSPACE = 3;
   localparam int SPACE_W = 2;
   localparam int WCODE_W = 2;

   // ==========================================
   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_PINCTL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_WIDTH = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_BASE0 = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_REMAP0 = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_BOOT = 8'h30;
   localparam logic [ADDR_W-1:0] OFS_STEP = 8'h04;

   // ==========================================
   // Pin control field positions
   localparam int BIT_USER_OUT = 16;
   localparam int BIT_USER_IN = 17;
   localparam int BIT_CLK = 24;
   localparam int BIT_SEL = 25;
   localparam int BIT_DOUT = 26;
   localparam int BIT_DIN = 27;
   localparam int BIT_IEN = 31;
   localparam int BIT_BASE_EN = 0;
   localparam logic [DATA_W-1:0] PINCTL_WMASK = 32'h8701_0000;
   localparam logic [DATA_W-1:0] PINCTL_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

   // ==========================================
   // Local width codes
   localparam logic [WCODE_W-1:0] WID_8 = 2'h0;
   localparam logic [WCODE_W-1:0] WID_16 = 2'h1;
   localparam logic [2:0] BYTES_1 = 3'h1;
   localparam logic [2:0] BYTES_2 = 3'h2;
   localparam logic [2:0] BYTES_4 = 3'h4;

   // ==========================================
   // Timing
   localparam int CLK_NS = 20;
   localparam int PROM_HALF_NS = 500;
   localparam int PROM_HALF_CYC = PROM_HALF_NS / CLK_NS;
   localparam int BOOT_BITS = 16;

   typedef enum logic [1:0] {BT_RUN, BT_DONE} pbfl_boot_e;
   typedef enum logic {DS_IDLE, DS_BEAT} pbfl_ds_e;
endpackage : pbfl_pkg

// ### rtl/pbfl_loader.sv
`timescale 1ns/1ns
module pbfl_loader #(
   parameter int WIN_BITS = 16,
   parameter int BOOT_BITS = pbfl_pkg::BOOT_BITS,
   parameter int HALF_CYC = pbfl_pkg::PROM_HALF_CYC,
   parameter bit BOOT_EN = 1'b1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [pbfl_pkg::ADDR_W-1:0] regAddr,
   input wire logic [pbfl_pkg::DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [pbfl_pkg::DATA_W-1:0] regRdData,
   input wire logic dsWr,
   input wire logic [pbfl_pkg::DATA_W-1:0] dsAddr,
   input wire logic [pbfl_pkg::DATA_W-1:0] dsData,
   output logic dsBusy,
   output logic localWr,
   output logic [pbfl_pkg::DATA_W-1:0] localAddr,
   output logic [pbfl_pkg::DATA_W-1:0] localData,
   output logic [pbfl_pkg::SPACE_W-1:0] localSpace,
   output logic bootDone,
   output logic serialPromClock,
   output logic serialPromSelect,
   output logic serialPromDataOutput,
   output logic serialPromDataOeN,
   input wire logic serialPromDataInput,
   output logic userOutputPin,
   input wire logic userInputPin
);
   import pbfl_pkg::*;

   // ==========================================
   // Helper functions
   // Bytes moved per local beat for a width code
   function automatic logic [2:0] stepBytes(
      input logic [WCODE_W-1:0] code
   );
      if (code == WID_8) begin
         return BYTES_1;
      end else if (code == WID_16) begin
         return BYTES_2;
      end
      return BYTES_4;
   endfunction : stepBytes

   // Beats per host word for a width code
   function automatic logic [2:0] beatCount(
      input logic [WCODE_W-1:0] code
   );
      if (code == WID_8) begin
         return BYTES_4;
      end else if (code == WID_16) begin
         return BYTES_2;
      end
      return BYTES_1;
   endfunction : beatCount

   // Enabled window compare
   function automatic logic spaceHit(
      input logic [DATA_W-1:0] addr,
      input logic [DATA_W-1:0] base
   );
      return base[BIT_BASE_EN] &&
         addr[DATA_W-1:WIN_BITS] == base[DATA_W-1:WIN_BITS];
   endfunction : spaceHit

   // ==========================================
   // Pin input synchronisers
   logic [1:0] sync1;
   logic [1:0] sync2;
   logic [1:0] sync3;
   logic [1:0] pinIn;
   logic dataIn;
   logic userIn;

   // Three stages, accept when last two agree
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sync1 <= 2'h0;
         sync2 <= 2'h0;
         sync3 <= 2'h0;
         pinIn <= 2'h0;
      end else begin
         sync1 <= {userInputPin, serialPromDataInput};
         sync2 <= sync1;
         sync3 <= sync2;
         for (int i = 0; i < 2; i++) begin
            if (sync2[i] == sync3[i]) begin
               pinIn[i] <= sync3[i];
            end
         end
      end
   end

   assign dataIn = pinIn[0];
   assign userIn = pinIn[1];

   // ==========================================
   // Registers
   logic [DATA_W-1:0] ctrl;
   logic [DATA_W-1:0] base [NSPACE];
   logic [DATA_W-1:0] remap [NSPACE];
   logic [NSPACE*WCODE_W-1:0] widthCfg;
   logic [BOOT_BITS-1:0] bootWord;
   logic pinCtlWr;

   assign pinCtlWr = regWr && regAddr == OFS_PINCTL;

   // Pin control, held until rewritten
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctrl <= PINCTL_RST;
      end else if (pinCtlWr) begin
         ctrl <= regWrData & PINCTL_WMASK;
      end
   end

   // Space windows and widths
   always_ff @(posedge clk) begin
      if (!nrst) begin
         widthCfg <= '0;
         for (int i = 0; i < NSPACE; i++) begin
            base[i] <= ZERO_WORD;
            remap[i] <= ZERO_WORD;
         end
      end else if (regWr) begin
         if (regAddr == OFS_WIDTH) begin
            widthCfg <= regWrData[NSPACE*WCODE_W-1:0];
         end
         for (int i = 0; i < NSPACE; i++) begin
            if (regAddr == OFS_BASE0 + ADDR_W'(i) * OFS_STEP) begin
               base[i] <= regWrData;
            end
            if (regAddr == OFS_REMAP0 + ADDR_W'(i) * OFS_STEP) begin
               remap[i] <= regWrData;
            end
         end
      end
   end

   // Read mux, unmapped reads zero
   logic [DATA_W-1:0] next_rdData;
   always_comb begin
      next_rdData = ZERO_WORD;
      if (regAddr == OFS_PINCTL) begin
         next_rdData = ctrl;
         next_rdData[BIT_USER_IN] = userIn;
         next_rdData[BIT_DIN] = dataIn & ctrl[BIT_IEN];
      end else if (regAddr == OFS_WIDTH) begin
         next_rdData[NSPACE*WCODE_W-1:0] = widthCfg;
      end else if (regAddr == OFS_BOOT) begin
         next_rdData[BOOT_BITS-1:0] = bootWord;
      end
      for (int i = 0; i < NSPACE; i++) begin
         if (regAddr == OFS_BASE0 + ADDR_W'(i) * OFS_STEP) begin
            next_rdData = base[i];
         end
         if (regAddr == OFS_REMAP0 + ADDR_W'(i) * OFS_STEP) begin
            next_rdData = remap[i];
         end
      end
   end

   // Read data valid one cycle after strobe
   always_ff @(posedge clk) begin
      if (!nrst) begin
         regRdData <= ZERO_WORD;
      end else if (regRd) begin
         regRdData <= next_rdData;
      end else begin
         regRdData <= ZERO_WORD;
      end
   end

   // ==========================================
   // Boot fetch from the serial PROM
   pbfl_boot_e bootState;
   logic [15:0] divCnt;
   logic tick;
   logic bootClk;
   logic [15:0] bitCnt;

   // Half period enable for the PROM clock
   always_ff @(posedge clk) begin
      if (!nrst) begin
         divCnt <= 16'h0000;
         tick <= 1'b0;
      end else if (divCnt == 16'(HALF_CYC - 1)) begin
         divCnt <= 16'h0000;
         tick <= 1'b1;
      end else begin
         divCnt <= divCnt + 16'h0001;
         tick <= 1'b0;
      end
   end

   // Clock bits in on rising edge, then idle
   always_ff @(posedge clk) begin
      if (!nrst) begin
         bootState <= BOOT_EN ? BT_RUN : BT_DONE;
         bootClk <= 1'b0;
         bitCnt <= 16'h0000;
         bootWord <= '0;
         bootDone <= 1'b0;
      end else begin
         unique case (bootState)
            BT_RUN: begin
               if (tick && !bootClk) begin
                  bootClk <= 1'b1;
                  bootWord <= {bootWord[BOOT_BITS-2:0], dataIn};
                  bitCnt <= bitCnt + 16'h0001;
               end else if (tick) begin
                  bootClk <= 1'b0;
                  if (bitCnt == 16'(BOOT_BITS)) begin
                     bootState <= BT_DONE;
                  end
               end
            end
            BT_DONE: begin
               bootClk <= 1'b0;
               bootDone <= 1'b1;
            end
         endcase
      end
   end

   // ==========================================
   // PROM and user pins
   // Boot owns the PROM pins while fetching, else software; user pin always software
   always_ff @(posedge clk) begin
      if (!nrst) begin
         serialPromClock <= 1'b0;
         serialPromSelect <= 1'b0;
         serialPromDataOutput <= 1'b0;
         serialPromDataOeN <= 1'b1;
         userOutputPin <= 1'b0;
      end else begin
         userOutputPin <= ctrl[BIT_USER_OUT];
         if (bootState == BT_RUN) begin
            serialPromClock <= bootClk;
            serialPromSelect <= 1'b1;
            serialPromDataOutput <= 1'b0;
            serialPromDataOeN <= 1'b1;
         end else begin
            serialPromClock <= ctrl[BIT_CLK];
            serialPromSelect <= ctrl[BIT_SEL];
            serialPromDataOutput <= ctrl[BIT_DOUT];
            serialPromDataOeN <= ctrl[BIT_IEN];
         end
      end
   end

   // ==========================================
   // Direct slave path to the local bus
   pbfl_ds_e dsState;
   logic hitAny;
   logic [SPACE_W-1:0] hitIdx;
   logic [WCODE_W-1:0] hitWid;
   logic [DATA_W-1:0] xlate;
   logic [2:0] step;
   logic [2:0] beatsLeft;

   // Lowest numbered enabled space wins
   always_comb begin
      hitAny = 1'b0;
      hitIdx = '0;
      for (int i = NSPACE - 1; i >= 0; i--) begin
         if (spaceHit(dsAddr, base[i])) begin
            hitAny = 1'b1;
            hitIdx = SPACE_W'(i);
         end
      end
      hitWid = widthCfg[hitIdx*WCODE_W +: WCODE_W];
      xlate = {remap[hitIdx][DATA_W-1:WIN_BITS],
         dsAddr[WIN_BITS-1:0]};
   end

   // Split host word into beats of the space width
   always_ff @(posedge clk) begin
      if (!nrst) begin
         dsState <= DS_IDLE;
         dsBusy <= 1'b0;
         localWr <= 1'b0;
         localAddr <= ZERO_WORD;
         localData <= ZERO_WORD;
         localSpace <= '0;
         step <= BYTES_4;
         beatsLeft <= 3'h0;
      end else begin
         unique case (dsState)
            DS_IDLE: begin
               localWr <= 1'b0;
               if (dsWr && hitAny) begin
                  localWr <= 1'b1;
                  localAddr <= xlate;
                  localData <= dsData;
                  localSpace <= hitIdx;
                  step <= stepBytes(hitWid);
                  beatsLeft <= beatCount(hitWid) - 3'h1;
                  if (beatCount(hitWid) != BYTES_1) begin
                     dsState <= DS_BEAT;
                     dsBusy <= 1'b1;
                  end
               end
            end
            DS_BEAT: begin
               localWr <= 1'b1;
               localAddr <= localAddr + DATA_W'(step);
               localData <= localData >> {step, 3'h0};
               beatsLeft <= beatsLeft - 3'h1;
               if (beatsLeft == 3'h1) begin
                  dsState <= DS_IDLE;
                  dsBusy <= 1'b0;
               end
            end
         endcase
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   rd_din_bit_a: assert property (
      regRd && regAddr == OFS_PINCTL |=>
         regRdData[BIT_DIN] == $past(dataIn & ctrl[BIT_IEN]))
      else $error("data input bit wrong on read");

   clk_follow_a: assert property (
      $past(bootState) == BT_DONE |->
         serialPromClock == $past(ctrl[BIT_CLK]))
      else $error("PROM clock not following control bit");

   sel_source_a: assert property (
      serialPromSelect |->
         $past(bootState == BT_RUN || ctrl[BIT_SEL]))
      else $error("select asserted without PROM access");

   dout_follow_a: assert property (
      $past(bootState) == BT_DONE |->
         serialPromDataOutput == $past(ctrl[BIT_DOUT]))
      else $error("data line level not following bit");

   ien_follow_a: assert property (
      $past(bootState) == BT_DONE |->
         serialPromDataOeN == $past(ctrl[BIT_IEN]))
      else $error("input enable not following bit");

   user_out_a: assert property (
      pinCtlWr ##1 !pinCtlWr |=>
         userOutputPin == $past(ctrl[BIT_USER_OUT]))
      else $error("user output not following bit");

   user_rst_a: assert property (
      $rose(nrst) |-> !userOutputPin)
      else $error("user output high after reset");

   ctrl_hold_a: assert property (
      !pinCtlWr |=> $stable(ctrl))
      else $error("pin control changed without write");

   boot_idle_a: assert property (
      bootState == BT_DONE |=> bootState == BT_DONE && !bootClk)
      else $error("boot fetch restarted");

   byte_beats_a: assert property (
      dsWr && !dsBusy && hitAny && hitWid == WID_8 |=>
         localWr [*4] ##1 !localWr)
      else $error("8 bit space did not give 4 beats");

   addr_xlate_a: assert property (
      dsWr && !dsBusy && hitAny |=> localAddr == $past(xlate))
      else $error("local address not translated");

   boot_cov: cover property (
      bootState == BT_RUN ##1 bootState == BT_DONE);
   byte_cov: cover property (
      localWr && dsBusy ##1 localWr && !dsBusy);
   sel_cov: cover property (
      bootState == BT_DONE && serialPromSelect);
   din_cov: cover property (
      regRd ##1 regRdData[BIT_DIN]);
endmodule : pbfl_loader

// ### tb/pbfl_far_side.sv
`timescale 1ns/1ns
// ==========================================
// Serial PROM and FPGA config input model
module pbfl_far_side #(
   parameter int BITS = 4,
   parameter logic [31:0] PATTERN = 32'h0000_000B
) (
   input wire logic clk,
   input wire logic promClock,
   input wire logic promSelect,
   input wire logic dataOut,
   input wire logic dataOeN,
   output logic lineLevel,
   output logic [31:0] fpgaShift
);
   int idx = 0;
   logic lastLevel = 1'b0;

   initial fpgaShift = 32'h0000_0000;

   // PROM restarts on select, next bit after each falling clock
   always @(posedge promSelect) idx = 0;
   always @(negedge promClock) if (promSelect) idx = idx + 1;

   // Wire level; a released line shows the PROM bit while selected with bits left, else toggles, never holds
   always_comb begin
      if (!dataOeN)
         lineLevel = dataOut;
      else if (promSelect && idx < BITS)
         lineLevel = PATTERN[BITS-1-idx];
      else
         lineLevel = ~lastLevel;
   end
   always @(posedge clk) lastLevel <= lineLevel;

   // FPGA latches one bit per rising clock, gated off by select
   always @(posedge promClock) begin
      if (!promSelect)
         fpgaShift <= {fpgaShift[30:0], lineLevel};
   end
endmodule : pbfl_far_side

// ### tb/pbfl_loader_tb.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin \
   comparisons++; \
   if ((got) !== (ex)) begin \
      errorCnt++; \
      $display("Error %s: expected %h, seen %h", nm, ex, got); \
   end \
end

// ==========================================
// Loader bench
module pbfl_loader_tb;
   import pbfl_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [ADDR_W-1:0] regAddr = 8'h00;
   logic [DATA_W-1:0] regWrData = 32'h0000_0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic dsWr = 1'b0;
   logic [DATA_W-1:0] dsAddr = 32'h0000_0000;
   logic [DATA_W-1:0] dsData = 32'h0000_0000;
   logic userInputPin = 1'b1;
   logic [DATA_W-1:0] regRdData, localAddr, localData, rd;
   logic dsBusy, localWr, bootDone, promClk, promSel, promOut, promOeN;
   logic lineLevel, userOut;
   logic sawSel = 1'b0;
   logic [SPACE_W-1:0] localSpace;
   logic [31:0] fpgaShift;
   logic [7:0] fpgaByte = 8'hA5;
   int errorCnt = 0;
   int comparisons = 0;

   pbfl_loader #(.HALF_CYC(8), .BOOT_BITS(4)) uut (
      .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .dsWr(dsWr),
      .dsAddr(dsAddr), .dsData(dsData), .dsBusy(dsBusy),
      .localWr(localWr), .localAddr(localAddr), .localData(localData),
      .localSpace(localSpace), .bootDone(bootDone),
      .serialPromClock(promClk), .serialPromSelect(promSel),
      .serialPromDataOutput(promOut), .serialPromDataOeN(promOeN),
      .serialPromDataInput(lineLevel), .userOutputPin(userOut),
      .userInputPin(userInputPin));

   pbfl_far_side #(.BITS(4), .PATTERN(32'h0000_000B)) farSide (
      .clk(clk), .promClock(promClk), .promSelect(promSel),
      .dataOut(promOut), .dataOeN(promOeN), .lineLevel(lineLevel),
      .fpgaShift(fpgaShift));

   // Clock and boot select monitor
   initial forever #10 clk = ~clk;
   always @(posedge clk) if (promSel && !bootDone) sawSel <= 1'b1;

   // Verdict and end of run
   task automatic wrapUp();
      $display("Comparisons %0d, errors %0d", comparisons, errorCnt);
      if (errorCnt == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrapUp

   // Register bus cycles
   task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : regWrite

   task automatic regRead(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      d = regRdData;
   endtask : regRead

   // Pin write, then wait for pins to follow
   task automatic pinWrite(input logic [31:0] d);
      regWrite(OFS_PINCTL, d);
      repeat (2) @(negedge clk);
   endtask : pinWrite

   // Direct slave write and its local beats
   task automatic dsCheck(input logic [31:0] a, input int beats,
         input int step, input logic [1:0] sp, input logic [31:0] la);
      logic [31:0] mask;
      logic [31:0] want;
      mask = (step == 4) ? 32'hFFFF_FFFF : (32'h1 << (8 * step)) - 32'h1;
      @(posedge clk);
      dsWr <= 1'b1;
      dsAddr <= a;
      dsData <= 32'h4433_2211;
      @(posedge clk);
      dsWr <= 1'b0;
      for (int i = 0; i < beats; i++) begin
         @(negedge clk);
         want = (32'h4433_2211 >> (8 * step * i)) & mask;
         `CHK("local strobe", 1'b1, localWr)
         `CHK("local addr", la + i * step, localAddr)
         `CHK("local data", want, localData & mask)
         `CHK("local space", sp, localSpace)
         `CHK("ds busy", i < beats - 1, dsBusy)
      end
      @(negedge clk);
      `CHK("strobe idle", 1'b0, localWr)
   endtask : dsCheck

   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      errorCnt++;
      wrapUp();
   end

   // Test sequence
   initial begin
      repeat (8) @(posedge clk);
      `CHK("user pin in reset", 1'b0, userOut)
      `CHK("data oe in reset", 1'b1, promOeN)
      nrst <= 1'b1;
      for (int i = 0; i < 300 && bootDone !== 1'b1; i++) @(negedge clk);
      `CHK("boot done", 1'b1, bootDone)
      `CHK("select in boot", 1'b1, sawSel)
      `CHK("select after boot", 1'b0, promSel)
      regRead(OFS_BOOT, rd);
      `CHK("boot word", 32'h0000_000B, rd)
      pinWrite(32'h0600_0000);
      `CHK("prom clock low", 1'b0, promClk)
      `CHK("prom select", 1'b1, promSel)
      `CHK("data level", 1'b1, promOut)
      `CHK("data driven", 1'b0, promOeN)
      regRead(OFS_PINCTL, rd);
      `CHK("input gated", 32'h0602_0000, rd)
      // Drive low first so the released read shows the PROM bit
      pinWrite(32'h0200_0000);
      `CHK("data level low", 1'b0, promOut)
      pinWrite(32'h8200_0000);
      `CHK("data released", 1'b1, promOeN)
      repeat (4) @(negedge clk);
      regRead(OFS_PINCTL, rd);
      `CHK("data input bit", 32'h8A02_0000, rd)
      pinWrite(32'h0100_0000);
      `CHK("prom clock", 1'b1, promClk)
      `CHK("select idle", 1'b0, promSel)
      pinWrite(32'h7DFF_FFFF);
      `CHK("user output", 1'b1, userOut)
      regRead(OFS_PINCTL, rd);
      `CHK("pin ctl mask", 32'h0503_0000, rd)
      @(posedge clk);
      userInputPin <= 1'b0;
      repeat (5) @(negedge clk);
      regRead(OFS_PINCTL, rd);
      `CHK("user input", 32'h0501_0000, rd)
      regWrite(8'h3C, 32'hFFFF_FFFF);
      regRead(8'h3C, rd);
      `CHK("unmapped", 32'h0000_0000, rd)
      `CHK("clock held", 1'b1, promClk)
      `CHK("data held", 1'b1, promOut)
      // Clock a byte into the FPGA, data ahead of each rise
      for (int i = 7; i >= 0; i--) begin
         pinWrite({5'h0, fpgaByte[i], 26'h0});
         pinWrite({5'h0, fpgaByte[i], 1'h0, 1'h1, 24'h0});
      end
      `CHK("fpga byte", fpgaByte, fpgaShift[7:0])
      regWrite(OFS_WIDTH, 32'h0000_0024);
      regWrite(OFS_BASE0, 32'h1234_0001);
      regWrite(OFS_BASE0 + 8'h04, 32'h5678_0001);
      regWrite(OFS_BASE0 + 8'h08, 32'h9ABC_0001);
      regWrite(OFS_REMAP0, 32'hAB00_0000);
      regWrite(OFS_REMAP0 + 8'h04, 32'hCD00_0000);
      regWrite(OFS_REMAP0 + 8'h08, 32'hEF00_0000);
      regRead(OFS_REMAP0, rd);
      `CHK("remap readback", 32'hAB00_0000, rd)
      dsCheck(32'h1234_0010, 4, 1, 2'h0, 32'hAB00_0010);
      dsCheck(32'h5678_0102, 2, 2, 2'h1, 32'hCD00_0102);
      dsCheck(32'h9ABC_FFFC, 1, 4, 2'h2, 32'hEF00_FFFC);
      dsCheck(32'h1235_0000, 0, 1, 2'h0, 32'h0000_0000);
      pinWrite(32'h0001_0000);
      `CHK("user out set", 1'b1, userOut)
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(negedge clk);
      `CHK("user pin reset", 1'b0, userOut)
      @(posedge clk);
      nrst <= 1'b1;
      // Second release restarts the boot fetch
      repeat (2) @(negedge clk);
      `CHK("boot restarts", 1'b1, promSel)
      `CHK("user pin low", 1'b0, userOut)
      wrapUp();
   end
endmodule : pbfl_loader_tb
